// file: hw/fep_range_check.sv
`timescale 1ns/1ps
`include "fep_defs.svh"

// Decodes whether an address or any sector of the array is protected
module fep_range_check
  import fep_pkg::*;
(
  input  wire logic [7:0]  prot_i,
  input  wire logic [22:0] addr_i,
  output logic             addr_prot_o,
  output logic             block_prot_o
);

  logic [22:0] hi_start;  // First address of high range
  logic [22:0] lo_end;    // First address past low range
  logic        in_pf;     // Address inside the protected array
  logic        in_hi;     // Address inside high range
  logic        in_lo;     // Address inside low range
  logic        hit;       // Address inside an enabled range

  // Range bounds from size codes
  always_comb begin
    // [R11] high range sizes
    hi_start = `FEP_PF_TOP - ((`FEP_HI_MIN_SIZE << prot_i[`FEP_BIT_HS_HI:`FEP_BIT_HS_LO]) - 23'h1);
    // [R12] low range sizes
    lo_end   = `FEP_LO_BASE + (`FEP_LO_MIN_SIZE << prot_i[`FEP_BIT_LS_HI:`FEP_BIT_LS_LO]);
  end

  // Range membership and polarity
  always_comb begin
    in_pf = (addr_i >= `FEP_PF_BASE);
    in_hi = (addr_i >= hi_start);
    in_lo = (addr_i >= `FEP_LO_BASE) && (addr_i < lo_end);
    hit   = (!prot_i[`FEP_BIT_HDIS] && in_hi) || (!prot_i[`FEP_BIT_LDIS] && in_lo);
    // [R9] polarity picks meaning
    // [R10] both disabled gives none or full
    if (prot_i[`FEP_BIT_POL]) begin
      addr_prot_o = in_pf && hit;
    end else begin
      addr_prot_o = in_pf && !hit;
    end
  end

  // Any sector of the block protected
  always_comb begin
    // [R8] block erase sector test
    if (prot_i[`FEP_BIT_POL]) begin
      block_prot_o = !prot_i[`FEP_BIT_HDIS] || !prot_i[`FEP_BIT_LDIS];
    end else begin
      // Unprotected ranges never cover the whole block
      block_prot_o = 1'b1;
    end
  end

endmodule : fep_range_check

// file: hw/fep_top.sv
// Contract
// [R1] Double fault or busy read sets flag
// [R2] Double flag clears only on written one
// [R3] Single fault sets flag unless ignored
// [R4] Single flag clears only on written one
// [R5] Reset loads protection from nonvolatile byte
// [R6] Load double fault forces full protection
// [R7] Protected program/erase refused, violation flagged
// [R8] Block erase refused if any protected
// [R9] Polarity selects protected or unprotected ranges
// [R10] Both disables: none or full protection
// [R11] High range top-anchored, 2 to 16K
// [R12] Low range base-anchored, 1 to 8K
// [R13] High size writable only when disabled
// [R14] Low size writable only when disabled
// [R15] Disallowed scenario writes ignored, reads active
// [R16] Allowed scenario transition table
// [R17] Software leaves reserved bit erased
// [R18] Scenario index is polarity, hdis, ldis
// [R19] Double flag with enable raises interrupt
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "fep_defs.svh"

module fep_top
  import fep_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Array read result events
  input  wire logic        ecc_single_i,
  input  wire logic        ecc_double_i,
  input  wire logic        read_busy_i,
  // Reset-time protection byte fetch
  input  wire logic        nv_load_valid_i,
  input  wire logic        nv_load_dfault_i,
  input  wire logic [7:0]  nv_prot_byte_i,
  // Program or erase request from command logic
  input  wire logic        cmd_req_i,
  input  wire logic        cmd_block_erase_i,
  input  wire logic [22:0] cmd_addr_i,
  output logic             cmd_accept_o,
  output logic             cmd_refuse_o,
  // Status toward neighbours
  output logic [7:0]       program_protect_o,
  output logic             protect_violation_o,
  output logic             load_busy_o,
  output logic             irq_o
);

  fep_state_t  state_reg;             // Load sequence state
  fep_state_t  state_next;            // Next load state
  logic [7:0]  program_protect_reg;   // Active protection byte
  logic [7:0]  prot_wr_next;          // Candidate protection byte
  logic [1:0]  error_status_reg;      // Sticky fault flags
  logic [1:0]  error_config_reg;      // Interrupt enables
  logic        flash_config_reg;      // Ignore single fault
  logic        pviol_reg;             // Protection violation flag
  logic        ack_reg;               // Bus acknowledge
  logic [31:0] dat_reg;               // Read data
  logic        irq_reg;               // Interrupt level
  logic        acc_reg;               // Command accepted pulse
  logic        ref_reg;               // Command refused pulse
  logic        bus_req;               // Request pending
  logic        wr_commit;             // Write takes effect now
  logic [3:0]  bus_idx;               // Word index
  logic        addr_prot;             // Command address protected
  logic        block_prot;            // Any sector protected
  logic        refuse;                // Command must be refused
  logic        single_set;            // Single flag set event
  logic        double_set;            // Double flag set event
  logic [7:0]  rd_byte;               // Read mux result
  logic        load_busy_reg;         // Load pending, registered

  // Word index from byte address
  function automatic logic [3:0] fep_index(input logic [7:0] adr);
    fep_index = adr[5:2];
  endfunction : fep_index

  // Register hit for a given index
  function automatic logic fep_hit(input logic [7:0] adr, input logic [3:0] idx);
    fep_hit = (adr[7:6] == 2'h0) && (fep_index(adr) == idx) && (adr[1:0] == 2'h0);
  endfunction : fep_hit

  // Scenario of a protection byte
  function automatic fep_scen_t fep_scen(input logic [7:0] p);
    // [R18] scenario bit order
    fep_scen = {p[`FEP_BIT_POL], p[`FEP_BIT_HDIS], p[`FEP_BIT_LDIS]};
  endfunction : fep_scen

  // Transition permitted from one scenario to another
  // One byte per source scenario; bit n allows target scenario n
  // A constant table keeps the check a single lookup
  function automatic logic fep_allowed(input fep_scen_t from_s, input fep_scen_t to_s);
    logic [63:0] tbl;
    logic [7:0]  row;
    tbl = `FEP_ALLOW_TABLE;
    row = tbl[{from_s, 3'h0} +: 8];
    fep_allowed = row[to_s];
  endfunction : fep_allowed

  assign bus_req   = cyc_i && stb_i;
  assign bus_idx   = fep_index(adr_i);
  // Writes land only at the edge where ack is seen
  // Ack drops in the next cycle, so one request writes once
  assign wr_commit = bus_req && we_i && ack_reg && sel_i[0];

  // Address and block decode
  // Both follow the active byte, so a protection change
  // governs commands from the next cycle on
  fep_range_check u_range (
    .prot_i       (program_protect_reg),
    .addr_i       (cmd_addr_i),
    .addr_prot_o  (addr_prot),
    .block_prot_o (block_prot)
  );

  // Refusal decision for a command
  always_comb begin
    // [R7] protected address refused
    // [R8] block erase needs clean block
    if (cmd_block_erase_i) begin
      refuse = block_prot;
    end else begin
      refuse = addr_prot;
    end
  end

  // Fault set events
  // A busy-block read counts as both faults; the ignore
  // bit only masks the single flag
  always_comb begin
    // [R1] double fault or busy read
    double_set = ecc_double_i || read_busy_i;
    // [R3] gated by ignore bit
    single_set = !flash_config_reg && (ecc_single_i || read_busy_i);
  end

  // Load sequence next state
  always_comb begin
    case (state_reg)
      FEP_ST_LOAD: begin
        if (nv_load_valid_i) begin
          state_next = FEP_ST_RUN;
        end else begin
          state_next = FEP_ST_LOAD;
        end
      end
      FEP_ST_RUN: begin
        state_next = FEP_ST_RUN;
      end
      default: begin
        state_next = FEP_ST_LOAD;
      end
    endcase
  end

  // Load sequence state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= FEP_ST_LOAD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Load-pending output from its own flop, no decode on the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_busy_reg <= 1'b1;
    end else begin
      // Follows the next state, so it moves with state_reg
      load_busy_reg <= (state_next == FEP_ST_LOAD);
    end
  end

  // Candidate protection byte from a bus write
  // Size fields are gated on the disable bits held now, not on
  // the ones being written, so the write that switches a range
  // off cannot also resize it
  always_comb begin
    prot_wr_next = program_protect_reg;
    prot_wr_next[`FEP_BIT_POL]  = dat_i[`FEP_BIT_POL];
    prot_wr_next[`FEP_BIT_HDIS] = dat_i[`FEP_BIT_HDIS];
    prot_wr_next[`FEP_BIT_LDIS] = dat_i[`FEP_BIT_LDIS];
    // Reserved bit keeps its loaded value
    // [R13] high size gated by disable
    if (program_protect_reg[`FEP_BIT_HDIS]) begin
      prot_wr_next[`FEP_BIT_HS_HI:`FEP_BIT_HS_LO] = dat_i[`FEP_BIT_HS_HI:`FEP_BIT_HS_LO];
    end
    // [R14] low size gated by disable
    if (program_protect_reg[`FEP_BIT_LDIS]) begin
      prot_wr_next[`FEP_BIT_LS_HI:`FEP_BIT_LS_LO] = dat_i[`FEP_BIT_LS_HI:`FEP_BIT_LS_LO];
    end
  end

  // Protection register
  // Reset holds full protection until the fetch completes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_protect_reg <= `FEP_RST_PROT;
    end else if (state_reg == FEP_ST_LOAD) begin
      if (nv_load_valid_i) begin
        // [R6] corrupt byte gives full protection
        if (nv_load_dfault_i) begin
          program_protect_reg <= `FEP_FULL_PROT;
        end else begin
          // [R5] load stored byte
          program_protect_reg <= nv_prot_byte_i;
        end
      end
    end else if (wr_commit && fep_hit(adr_i, `FEP_IDX_PROT)) begin
      // [R15] drop disallowed writes
      // [R16] transition table check
      if (fep_allowed(fep_scen(program_protect_reg), fep_scen(prot_wr_next))) begin
        program_protect_reg <= prot_wr_next;
      end
    end
  end

  // Error status flags; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_status_reg <= `FEP_RST_ERR_STAT;
    end else begin
      // [R2] clear on written one
      // [R1] set has priority
      if (double_set) begin
        error_status_reg[`FEP_BIT_DFAULT] <= 1'b1;
      end else if (wr_commit && fep_hit(adr_i, `FEP_IDX_ERR_STAT) && dat_i[`FEP_BIT_DFAULT]) begin
        error_status_reg[`FEP_BIT_DFAULT] <= 1'b0;
      end
      // [R4] clear on written one
      // [R3] set has priority
      if (single_set) begin
        error_status_reg[`FEP_BIT_SFAULT] <= 1'b1;
      end else if (wr_commit && fep_hit(adr_i, `FEP_IDX_ERR_STAT) && dat_i[`FEP_BIT_SFAULT]) begin
        error_status_reg[`FEP_BIT_SFAULT] <= 1'b0;
      end
    end
  end

  // Interrupt enables and ignore bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_config_reg <= `FEP_RST_CFG;
      flash_config_reg <= 1'b0;
    end else if (wr_commit) begin
      if (fep_hit(adr_i, `FEP_IDX_ERR_CFG)) begin
        error_config_reg <= dat_i[1:0];
      end
      if (fep_hit(adr_i, `FEP_IDX_FLASH_CFG)) begin
        flash_config_reg <= dat_i[`FEP_BIT_IGN_SF];
      end
    end
  end

  // Command check pulses and violation flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg   <= 1'b0;
      ref_reg   <= 1'b0;
      pviol_reg <= 1'b0;
    end else begin
      // Commands are refused until the protection byte is loaded
      acc_reg <= cmd_req_i && (state_reg == FEP_ST_RUN) && !refuse;
      ref_reg <= cmd_req_i && ((state_reg != FEP_ST_RUN) || refuse);
      // A refusal during the load is not a violation; protection
      // is not known yet, so the sticky flag is left alone
      // [R7] flag a violation
      if (cmd_req_i && (state_reg == FEP_ST_RUN) && refuse) begin
        pviol_reg <= 1'b1;
      end else if (wr_commit && fep_hit(adr_i, `FEP_IDX_MAIN_STAT) && dat_i[`FEP_BIT_PVIOL]) begin
        pviol_reg <= 1'b0;
      end
    end
  end

  // Level interrupt from masked flags
  // One cycle behind the flags; a clear drops it a cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      // [R19] enabled flags raise the line
      irq_reg <= |(error_status_reg & error_config_reg);
    end
  end

  // Read mux; unmapped words read zero
  // Captured into dat_reg, so the bus never sees it change
  // while ack stands
  always_comb begin
    rd_byte = 8'h00;
    if (fep_hit(adr_i, `FEP_IDX_ERR_STAT)) begin
      rd_byte = {6'h00, error_status_reg};
    end else if (fep_hit(adr_i, `FEP_IDX_PROT)) begin
      // [R15] active scenario reads back
      rd_byte = program_protect_reg;
    end else if (fep_hit(adr_i, `FEP_IDX_ERR_CFG)) begin
      rd_byte = {6'h00, error_config_reg};
    end else if (fep_hit(adr_i, `FEP_IDX_FLASH_CFG)) begin
      rd_byte = {7'h00, flash_config_reg};
    end else if (fep_hit(adr_i, `FEP_IDX_MAIN_STAT)) begin
      rd_byte = 8'h00;
      rd_byte[`FEP_BIT_PVIOL] = pviol_reg;
    end
  end

  // Bus answer: one wait state, ack for one cycle
  // Limitation: back-to-back requests need an idle cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Output drive straight from flops
  assign dat_o               = dat_reg;
  assign ack_o               = ack_reg;
  assign irq_o               = irq_reg;
  assign cmd_accept_o        = acc_reg;
  assign cmd_refuse_o        = ref_reg;
  assign program_protect_o   = program_protect_reg;
  assign protect_violation_o = pviol_reg;
  assign load_busy_o         = load_busy_reg;

endmodule : fep_top

// file: inc/fep_defs.svh
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// Register indices; byte address is four times the index
`define FEP_IDX_FLASH_CFG   4'h4
`define FEP_IDX_ERR_CFG     4'h5
`define FEP_IDX_MAIN_STAT   4'h6
`define FEP_IDX_ERR_STAT    4'h7
`define FEP_IDX_PROT        4'h8

// Error status and error config field positions
`define FEP_BIT_SFAULT      0
`define FEP_BIT_DFAULT      1
// Flash config field position
`define FEP_BIT_IGN_SF      0
// Main status field position
`define FEP_BIT_PVIOL       4

// Protection register field positions
`define FEP_BIT_POL         7
`define FEP_BIT_RSV_NV      6
`define FEP_BIT_HDIS        5
`define FEP_BIT_HS_HI       4
`define FEP_BIT_HS_LO       3
`define FEP_BIT_LDIS        2
`define FEP_BIT_LS_HI       1
`define FEP_BIT_LS_LO       0

// Reset values
`define FEP_RST_PROT        8'h7f
`define FEP_RST_ERR_STAT    2'h0
`define FEP_RST_CFG         2'h0
`define FEP_FULL_PROT       8'h7f

// Address map of the protected array
`define FEP_PF_BASE         23'h7c_0000
`define FEP_PF_TOP          23'h7f_ffff
`define FEP_HI_MIN_SIZE     23'h00_0800
`define FEP_LO_BASE         23'h7f_8000
`define FEP_LO_MIN_SIZE     23'h00_0400

// Allowed target scenarios, one mask per source scenario
`define FEP_ALLOW_TABLE     64'hff_5a_3c_18_08_0c_0a_0f

`endif

// file: inc/fep_pkg.sv
package fep_pkg;

  // Protection load sequence after reset
  typedef enum logic [0:0] {
    FEP_ST_LOAD = 1'b0,
    FEP_ST_RUN  = 1'b1
  } fep_state_t;

  // Scenario index {polarity, high disable, low disable}
  typedef logic [2:0] fep_scen_t;

endpackage : fep_pkg

// file: sim/fep_top_properties.sv
`timescale 1ns/1ps
// Port-level checks on the flag and protection block
module fep_top_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       we_i,
  input wire logic [7:0] adr_i,
  input wire logic       ack_o,
  input wire logic       nv_load_valid_i,
  input wire logic       nv_load_dfault_i,
  input wire logic [7:0] nv_prot_byte_i,
  input wire logic       cmd_req_i,
  input wire logic       cmd_accept_o,
  input wire logic       cmd_refuse_o,
  input wire logic [7:0] program_protect_o,
  input wire logic       protect_violation_o,
  input wire logic       load_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Active scenario {polarity, high off, low off}
  wire [2:0] scen = {program_protect_o[7], program_protect_o[5], program_protect_o[2]};
  sequence s_live_cmd; cmd_req_i && !load_busy_o; endsequence
  sequence s_load(df); load_busy_o && nv_load_valid_i && (nv_load_dfault_i == df); endsequence
  property p_one_answer; cmd_req_i |=> cmd_accept_o != cmd_refuse_o; endproperty
  property p_busy_refuse; cmd_req_i && load_busy_o |=> cmd_refuse_o && !protect_violation_o; endproperty
  property p_viol; s_live_cmd ##1 cmd_refuse_o |-> protect_violation_o; endproperty
  property p_full; s_live_cmd and scen == 3'b011 |=> cmd_refuse_o; endproperty
  property p_none; s_live_cmd and scen == 3'b111 |=> cmd_accept_o; endproperty
  property p_wait; load_busy_o && !nv_load_valid_i |=> load_busy_o && program_protect_o == 8'h7f; endproperty
  property p_load; s_load(1'b0) |=> !load_busy_o && program_protect_o == $past(nv_prot_byte_i); endproperty
  property p_load_df; s_load(1'b1) |=> !load_busy_o && program_protect_o == 8'h7f; endproperty
  // Only a write or the load may move protection
  property p_hold; $changed(program_protect_o) |-> $past(ack_o && we_i && adr_i == 8'h20) || $past(nv_load_valid_i);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("command not answered once");
  a_busy_refuse: assert property (p_busy_refuse) else $error("command during load");
  a_viol: assert property (p_viol) else $error("refuse without violation flag");
  a_full: assert property (p_full) else $error("full protection let command pass");
  a_none: assert property (p_none) else $error("no protection refused command");
  a_wait: assert property (p_wait) else $error("protection moved before load");
  a_load: assert property (p_load) else $error("loaded byte wrong");
  a_load_df: assert property (p_load_df) else $error("faulty load not full protection");
  a_hold: assert property (p_hold) else $error("protection changed on its own");
endmodule : fep_top_properties

bind fep_top fep_top_properties u_props (.clk_i, .rst_i, .we_i, .adr_i, .ack_o, .nv_load_valid_i, .nv_load_dfault_i,
  .nv_prot_byte_i, .cmd_req_i, .cmd_accept_o, .cmd_refuse_o, .program_protect_o, .protect_violation_o, .load_busy_o);

// file: sim/flash_error_flags_and_program_protection_bench.sv
`timescale 1ns/1ps
module flash_error_flags_and_program_protection_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00, nv_prot_byte_i = 8'h00, program_protect_o;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ecc_single_i = 1'b0, ecc_double_i = 1'b0, read_busy_i = 1'b0;
  logic        nv_load_valid_i = 1'b0, nv_load_dfault_i = 1'b0, cmd_req_i = 1'b0, cmd_block_erase_i = 1'b0;
  logic [22:0] cmd_addr_i = 23'h0;
  logic        ack_o, cmd_accept_o, cmd_refuse_o, protect_violation_o, load_busy_o, irq_o;
  int          err_total = 0, n_compared = 0, cycles = 0;
  fep_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .ecc_single_i,
    .ecc_double_i, .read_busy_i, .nv_load_valid_i, .nv_load_dfault_i, .nv_prot_byte_i, .cmd_req_i,
    .cmd_block_erase_i, .cmd_addr_i, .cmd_accept_o, .cmd_refuse_o, .program_protect_o, .protect_violation_o,
    .load_busy_o, .irq_o);
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  // Cut a hung run short; the whole run needs well under this
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  // Classic cycle; waits for ack, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk
  // Command pulse, answer judged in the following cycle
  task cmd(input logic be, input logic [22:0] a, input logic rf);
    cmd_req_i <= 1'b1; cmd_block_erase_i <= be; cmd_addr_i <= a;
    @(posedge clk_i);
    cmd_req_i <= 1'b0;
    @(posedge clk_i);
    chk("refuse", rf, cmd_refuse_o);
    chk("accept", !rf, cmd_accept_o);
  endtask : cmd
  // Events ordered {single, double, busy read}
  task pulse(input logic [2:0] e);
    {ecc_single_i, ecc_double_i, read_busy_i} <= e;
    @(posedge clk_i);
    {ecc_single_i, ecc_double_i, read_busy_i} <= 3'b000;
    @(posedge clk_i);
  endtask : pulse
  task load(input logic df, input logic [7:0] b);
    nv_load_valid_i <= 1'b1; nv_load_dfault_i <= df; nv_prot_byte_i <= b;
    @(posedge clk_i);
    nv_load_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask : load
  task do_reset;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  task t_reset;
    do_reset();
    chk("protect", 8'h7f, program_protect_o);
    chk("load busy", 1'b1, load_busy_o);
    cmd(1'b0, 23'h7c_0000, 1'b1);
    chk("violation", 1'b0, protect_violation_o);
    load(1'b1, 8'hff);
    chk("protect", 8'h7f, program_protect_o);
    chk("load busy", 1'b0, load_busy_o);
    wb(1'b1, 8'h20, 32'hff);
    rdchk("protect reg", 8'h20, 32'h7f);
    cmd(1'b0, 23'h7f_0000, 1'b1);
    do_reset();
    load(1'b0, 8'hff);
    chk("protect", 8'hff, program_protect_o);
    cmd(1'b1, 23'h7c_0000, 1'b0);
    $display("reset and load test done");
  endtask : t_reset
  task t_flags;
    pulse(3'b010);
    rdchk("err status", 8'h1c, 32'h2);
    wb(1'b1, 8'h1c, 32'h0);
    rdchk("err status", 8'h1c, 32'h2);
    wb(1'b1, 8'h1c, 32'h2);
    rdchk("err status", 8'h1c, 32'h0);
    pulse(3'b100);
    wb(1'b1, 8'h1c, 32'h2);
    rdchk("err status", 8'h1c, 32'h1);
    wb(1'b1, 8'h1c, 32'h1);
    rdchk("err status", 8'h1c, 32'h0);
    wb(1'b1, 8'h10, 32'h1);
    pulse(3'b100);
    pulse(3'b001);
    rdchk("err status", 8'h1c, 32'h2);
    wb(1'b1, 8'h10, 32'h0);
    pulse(3'b001);
    rdchk("err status", 8'h1c, 32'h3);
    wb(1'b1, 8'h1c, 32'h3);
    $display("error flag test done");
  endtask : t_flags
  task t_irq;
    wb(1'b1, 8'h14, 32'h2);
    pulse(3'b010);
    @(posedge clk_i);
    chk("irq", 1'b1, irq_o);
    wb(1'b1, 8'h14, 32'h0);
    @(posedge clk_i);
    chk("irq", 1'b0, irq_o);
    wb(1'b1, 8'h14, 32'h2);
    @(posedge clk_i);
    chk("irq", 1'b1, irq_o);
    wb(1'b1, 8'h1c, 32'h2);
    @(posedge clk_i);
    chk("irq", 1'b0, irq_o);
    $display("interrupt test done");
  endtask : t_irq
  // From no protection to protected high 16K, then to full
  task t_prot;
    wb(1'b1, 8'h20, 32'hdc);
    rdchk("protect reg", 8'h20, 32'hdc);
    cmd(1'b0, 23'h7f_c000, 1'b1);
    chk("violation", 1'b1, protect_violation_o);
    cmd(1'b0, 23'h7f_bfff, 1'b0);
    cmd(1'b1, 23'h7c_0000, 1'b1);
    wb(1'b1, 8'h18, 32'h10);
    rdchk("main status", 8'h18, 32'h0);
    wb(1'b1, 8'h20, 32'hff);
    rdchk("protect reg", 8'h20, 32'hdc);
    wb(1'b1, 8'h20, 32'hc4);
    rdchk("protect reg", 8'h20, 32'hdc);
    wb(1'b1, 8'h20, 32'h67);
    rdchk("protect reg", 8'h20, 32'h7f);
    cmd(1'b0, 23'h7c_0000, 1'b1);
    rdchk("unmapped", 8'h24, 32'h0);
    $display("protection test done");
  endtask : t_prot
  // Protected low 8K, then unprotected high 2K with polarity clear
  task t_low;
    do_reset();
    load(1'b0, 8'hfb);
    chk("protect", 8'hfb, program_protect_o);
    cmd(1'b0, 23'h7f_9fff, 1'b1);
    cmd(1'b0, 23'h7f_a000, 1'b0);
    wb(1'b1, 8'h20, 32'hf8);
    rdchk("protect reg", 8'h20, 32'hfb);
    wb(1'b1, 8'h20, 32'h44);
    rdchk("protect reg", 8'h20, 32'h47);
    cmd(1'b0, 23'h7f_f800, 1'b0);
    cmd(1'b0, 23'h7f_f7ff, 1'b1);
    cmd(1'b1, 23'h7f_f800, 1'b1);
    $display("low range test done");
  endtask : t_low
  initial begin
    t_reset();
    t_flags();
    t_irq();
    t_prot();
    t_low();
    end_of_test();
  end
endmodule : flash_error_flags_and_program_protection_bench
